// ===== logic/crp_pkg.sv
package crp_pkg;

    // ============================================================
    // Clock division
    localparam int OSC_DIV_SYS     = 32;
    localparam int OSC_DIV_BIT     = 64;
    localparam int MID_EDGE_MIN    = (OSC_DIV_BIT * 3) / 4;

    // ============================================================
    // Frame layout
    localparam int GUARD_BITS      = 16;
    localparam int PIXEL_BITS      = 12;
    localparam int TRAIL_BITS      = 16;
    localparam int LEVEL_W         = 4;
    localparam int PWM_SLOTS       = 16;
    localparam int IDLE_SYS_TICKS  = 8;
    localparam int QUEUE_DEPTH     = 16;
    localparam int TX_PREFILL      = 8;

    // ============================================================
    // Register port map
    localparam logic [1:0]  REG_LEVELS     = 2'h0;
    localparam logic [1:0]  REG_STATUS     = 2'h1;
    localparam logic [1:0]  REG_CONTROL    = 2'h2;
    localparam int          CTRL_OUT_EN    = 0;
    localparam int          CTRL_FWD_EN    = 1;
    localparam logic [1:0]  CTRL_RESET     = 2'h3;
    localparam logic [15:0] RDATA_RESET    = 16'h0000;

endpackage

// ===== logic/crp_pwm_if.sv
// ============================================================
// Slot clock and colour levels handed to the PWM generator.
interface crp_pwm_if;
    logic       slot_tick;
    logic [3:0] level_red;
    logic [3:0] level_green;
    logic [3:0] level_blue;
    logic [2:0] drive;

    modport ctrl (output slot_tick, output level_red, output level_green, output level_blue, input drive);
    modport gen  (input slot_tick, input level_red, input level_green, input level_blue, output drive);
endinterface

// ===== logic/crp_pwm.sv
// ============================================================
// Three-channel 16-slot PWM generator.
module crp_pwm (
    input  wire logic clk_sys,
    input  wire logic reset,
    crp_pwm_if.gen    pwm
);
    logic [3:0] slot_reg;
    logic [2:0] drive_reg;
    logic [2:0] drive_next;

    function automatic logic slot_on(input logic [3:0] level, input logic [3:0] slot);
        // Full scale is held on for every slot, so 15 does not leave one dark slot.
        slot_on = (level == 4'hF) || (slot < level);
    endfunction

    // Channel decisions for the slot now running.
    assign drive_next = {slot_on(pwm.level_blue, slot_reg),
                         slot_on(pwm.level_green, slot_reg),
                         slot_on(pwm.level_red, slot_reg)};
    assign pwm.drive = drive_reg;

    // One slot per PWM clock, wrapping after 16 slots.
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            slot_reg  <= 4'h0;
            drive_reg <= 3'h0;
        end else if (pwm.slot_tick) begin
            slot_reg  <= slot_reg + 4'h1;
            drive_reg <= drive_next;
        end
    end
endmodule

// ===== logic/crp_top.sv
// ============================================================
// Cascaded pixel receiver, forwarder and LED driver.
//
// Decided for this implementation: the plain strobed port and the register addresses.
module crp_top (
    input  wire logic        clk_sys,
    input  wire logic        reset,
    input  wire logic        xtal_in,
    output logic             xtal_out,
    input  wire logic        serial_in,
    input  wire logic        bit_clock_in,
    input  wire logic        chain_sys_clock_in,
    input  wire logic        rx_port_mode_sel,
    input  wire logic        tx_port_mode_sel,
    output logic             serial_out,
    output logic             bit_clock_out,
    output logic             chain_sys_clock_out,
    output logic             led_red,
    output logic             led_green,
    output logic             led_blue,
    input  wire logic [1:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic [15:0]      reg_rdata
);
    crp_pwm_if pwm_bus ();

    // ============================================================
    // Clock sources
    logic        xtal_q_reg;
    logic        xtal_out_reg;
    logic [5:0]  osc_cnt_reg;
    logic        up_sys_q_reg;
    logic        osc_tick;
    logic        osc_sys_tick;
    logic        up_sys_tick;
    logic        sys_tick;
    logic        sys_level;

    // Oscillator edges are counted on the fast clock; each rising edge is one oscillator period.
    assign osc_tick     = xtal_in & ~xtal_q_reg;
    assign osc_sys_tick = osc_tick && (osc_cnt_reg[4:0] == 5'(crp_pkg::OSC_DIV_SYS - 1));
    assign up_sys_tick  = chain_sys_clock_in & ~up_sys_q_reg;
    // The system clock follows the upstream chip in clock-latched input mode.
    assign sys_tick     = rx_port_mode_sel ? up_sys_tick : osc_sys_tick;
    assign sys_level    = rx_port_mode_sel ? chain_sys_clock_in : osc_cnt_reg[4];

    // The upstream clock sampler resets high so a clock resting high shows no false rise; the crystal sampler resets low and its inverter is registered.
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            xtal_q_reg   <= 1'b0;
            xtal_out_reg <= 1'b0;
            up_sys_q_reg <= 1'b1;
        end else begin
            xtal_q_reg   <= xtal_in;
            xtal_out_reg <= ~xtal_in;
            up_sys_q_reg <= chain_sys_clock_in;
        end
    end

    // Six-bit divider: bit 4 is the system clock, the full wrap is the bit clock.
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            osc_cnt_reg <= 6'h00;
        end else if (osc_tick) begin
            osc_cnt_reg <= osc_cnt_reg + 6'h01;
        end
    end

    // ============================================================
    // Receive front end
    logic        din_q_reg;
    logic        bclk_q_reg;
    logic [6:0]  man_cnt_reg;
    logic        in_frame_reg;
    logic        line_edge;
    logic        man_valid;
    logic        latch_valid;
    logic        rx_valid;
    logic        rx_bit;

    // Plain data is sampled on each rising edge of the incoming bit clock; the line-code decoder
    // is idle then, and the bit clock is ignored while the input strap is low.
    assign latch_valid = rx_port_mode_sel & bit_clock_in & ~bclk_q_reg;
    assign line_edge   = serial_in ^ din_q_reg;
    // A transition counts as mid-bit only after three quarters of a bit time, which skips the
    // boundary transitions between equal bits. After idle the first transition is a mid-bit one.
    assign man_valid   = ~rx_port_mode_sel & line_edge &
                         (~in_frame_reg | (man_cnt_reg >= 7'(crp_pkg::MID_EDGE_MIN)));
    assign rx_valid    = latch_valid | man_valid;
    // High-then-low is a one, so the bit is the level held before the mid-bit transition.
    assign rx_bit      = rx_port_mode_sel ? serial_in : din_q_reg;

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            din_q_reg  <= 1'b0;
            bclk_q_reg <= 1'b1;
        end else begin
            din_q_reg  <= serial_in;
            bclk_q_reg <= bit_clock_in;
        end
    end

    // Oscillator periods since the last decoded mid-bit transition, saturating.
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            man_cnt_reg <= 7'h00;
        end else if (man_valid) begin
            man_cnt_reg <= 7'h00;
        end else if (osc_tick && man_cnt_reg != 7'h7F) begin
            man_cnt_reg <= man_cnt_reg + 7'h01;
        end
    end

    // ============================================================
    // Frame tracking
    logic [15:0] bit_cnt_reg;
    logic [3:0]  idle_cnt_reg;
    logic [11:0] pix_sr_reg;
    logic        pix_got_reg;
    logic [11:0] pix_reg;
    logic [7:0]  frame_cnt_reg;
    logic        in_guard;
    logic        in_first_pix;
    logic        frame_end;
    logic        frame_ok;

    assign in_guard     = bit_cnt_reg < 16'(crp_pkg::GUARD_BITS);
    assign in_first_pix = !in_guard &&
                          bit_cnt_reg < 16'(crp_pkg::GUARD_BITS + crp_pkg::PIXEL_BITS);
    // The frame closes once the line has been quiet for a few system clocks.
    assign frame_end    = in_frame_reg && sys_tick && !rx_valid &&
                          idle_cnt_reg == 4'(crp_pkg::IDLE_SYS_TICKS - 1);
    // A frame too short to hold guard, one pixel and trailer leaves the levels alone.
    assign frame_ok     = pix_got_reg && bit_cnt_reg >=
                          16'(crp_pkg::GUARD_BITS + crp_pkg::PIXEL_BITS + crp_pkg::TRAIL_BITS);

    // Bit position within the frame and the quiet-line timer.
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            in_frame_reg <= 1'b0;
            bit_cnt_reg  <= 16'h0000;
            idle_cnt_reg <= 4'h0;
        end else if (rx_valid) begin
            in_frame_reg <= 1'b1;
            idle_cnt_reg <= 4'h0;
            if (bit_cnt_reg != 16'hFFFF) begin
                bit_cnt_reg <= bit_cnt_reg + 16'h0001;
            end
        end else if (frame_end) begin
            in_frame_reg <= 1'b0;
            bit_cnt_reg  <= 16'h0000;
            idle_cnt_reg <= 4'h0;
        end else if (in_frame_reg && sys_tick) begin
            idle_cnt_reg <= idle_cnt_reg + 4'h1;
        end
    end

    // First pixel capture, MSB first, red nibble arriving first.
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            pix_sr_reg  <= 12'h000;
            pix_got_reg <= 1'b0;
        end else if (rx_valid && in_first_pix) begin
            pix_sr_reg  <= {pix_sr_reg[10:0], rx_bit};
            pix_got_reg <= bit_cnt_reg == 16'(crp_pkg::GUARD_BITS + crp_pkg::PIXEL_BITS - 1);
        end else if (frame_end) begin
            pix_got_reg <= 1'b0;
        end
    end

    // Levels change only at frame end, so a frame cut short never shows a half-loaded pixel.
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            pix_reg       <= 12'h000;
            frame_cnt_reg <= 8'h00;
        end else if (frame_end && frame_ok) begin
            pix_reg       <= pix_sr_reg;
            frame_cnt_reg <= frame_cnt_reg + 8'h01;
        end
    end

    // ============================================================
    // Forwarding queue
    logic [1:0]  ctrl_reg;
    logic [15:0] q_reg;
    logic [4:0]  q_cnt_reg;
    logic [15:0] q_next;
    logic [4:0]  q_cnt_next;
    logic        push;
    logic        pop;
    logic        push_bit;
    logic        q_empty;
    logic        q_full;

    assign q_empty  = q_cnt_reg == 5'h00;
    assign q_full   = q_cnt_reg == 5'(crp_pkg::QUEUE_DEPTH);
    // Guard bits are regenerated as zeros so a line-coded receiver downstream can lock on them.
    assign push_bit = in_guard ? 1'b0 : rx_bit;
    // The own pixel is dropped; everything else is passed on when forwarding is enabled and the queue is not full.
    assign push     = rx_valid & ~in_first_pix & ctrl_reg[crp_pkg::CTRL_FWD_EN] & ~q_full;

    // Head of queue is bit 0; a pop shifts the queue down before the new bit lands.
    always_comb begin
        q_next     = pop ? {1'b0, q_reg[15:1]} : q_reg;
        q_cnt_next = q_cnt_reg - {4'h0, pop};
        if (push) begin
            q_next[q_cnt_next[3:0]] = push_bit;
            q_cnt_next              = q_cnt_next + 5'h01;
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            q_reg     <= 16'h0000;
            q_cnt_reg <= 5'h00;
        end else begin
            q_reg     <= q_next;
            q_cnt_reg <= q_cnt_next;
        end
    end

    // ============================================================
    // Transmitter
    logic        tx_active_reg;
    logic        tx_half_reg;
    logic        tx_bit_reg;
    logic        tx_load;
    logic        tx_start_ok;
    logic        tx_line;
    logic        serial_out_reg;
    logic        bit_clock_out_reg;
    logic        sys_clock_out_reg;

    // A new frame waits for a few bits so a slower upstream rate does not starve it mid-frame.
    assign tx_start_ok = tx_active_reg | ~in_frame_reg | (q_cnt_reg >= 5'(crp_pkg::TX_PREFILL));
    // Each bit lasts two system clocks, giving oscillator over 64 in line-coded input mode, where the oscillator drives the system clock.
    assign tx_load     = sys_tick & (~tx_active_reg | tx_half_reg);
    assign pop         = tx_load & ~q_empty & tx_start_ok;
    // Plain data holds for the whole bit; the line code inverts in the second half.
    assign tx_line     = tx_active_reg &
                         (tx_port_mode_sel ? tx_bit_reg : (tx_bit_reg ^ tx_half_reg));

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            tx_active_reg <= 1'b0;
            tx_half_reg   <= 1'b0;
            tx_bit_reg    <= 1'b0;
        end else if (pop) begin
            tx_active_reg <= 1'b1;
            tx_half_reg   <= 1'b0;
            tx_bit_reg    <= q_reg[0];
        end else if (tx_load) begin
            tx_active_reg <= 1'b0;
            tx_half_reg   <= 1'b0;
        end else if (sys_tick) begin
            tx_half_reg   <= 1'b1;
        end
    end

    // Line pins; the clocks stay low while the output strap selects the line code.
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            serial_out_reg    <= 1'b0;
            bit_clock_out_reg <= 1'b0;
            sys_clock_out_reg <= 1'b0;
        end else begin
            serial_out_reg    <= tx_line;
            bit_clock_out_reg <= tx_port_mode_sel & tx_active_reg & tx_half_reg;
            sys_clock_out_reg <= tx_port_mode_sel & sys_level;
        end
    end

    // ============================================================
    // PWM hookup
    logic        out_en;

    // Blanking forces level zero rather than gating pins, so the generator stays glitch free.
    assign out_en               = ctrl_reg[crp_pkg::CTRL_OUT_EN];
    assign pwm_bus.slot_tick    = sys_tick;
    assign pwm_bus.level_red    = out_en ? pix_reg[11:8] : 4'h0;
    assign pwm_bus.level_green  = out_en ? pix_reg[7:4] : 4'h0;
    assign pwm_bus.level_blue   = out_en ? pix_reg[3:0] : 4'h0;

    crp_pwm u_pwm (
        .clk_sys (clk_sys),
        .reset   (reset),
        .pwm     (pwm_bus.gen)
    );

    // ============================================================
    // Register port
    logic [15:0] rdata_reg;
    logic [15:0] rdata_sel;
    logic [15:0] status_word;

    assign status_word = {frame_cnt_reg, q_full, 2'h0, in_frame_reg, tx_active_reg,
                          pix_got_reg, tx_port_mode_sel, rx_port_mode_sel};
    assign rdata_sel   = (reg_addr == crp_pkg::REG_LEVELS)  ? {4'h0, pix_reg} :
                         (reg_addr == crp_pkg::REG_STATUS)  ? status_word :
                         (reg_addr == crp_pkg::REG_CONTROL) ? {14'h0000, ctrl_reg} :
                         16'h0000;

    // Read data stands only in the cycle after the strobe and is zero otherwise.
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            rdata_reg <= crp_pkg::RDATA_RESET;
            ctrl_reg  <= crp_pkg::CTRL_RESET;
        end else begin
            rdata_reg <= reg_rd ? rdata_sel : 16'h0000;
            if (reg_wr && reg_addr == crp_pkg::REG_CONTROL) begin
                ctrl_reg <= reg_wdata[1:0];
            end
        end
    end

    assign xtal_out            = xtal_out_reg;
    assign serial_out          = serial_out_reg;
    assign bit_clock_out       = bit_clock_out_reg;
    assign chain_sys_clock_out = sys_clock_out_reg;
    assign led_red             = pwm_bus.drive[0];
    assign led_green           = pwm_bus.drive[1];
    assign led_blue            = pwm_bus.drive[2];
    assign reg_rdata           = rdata_reg;
endmodule

// ===== tb/crp_top_checker.sv
// ============================================================
// Port-level checker for the pixel receiver and LED driver.
module crp_top_checker (
    input wire logic        clk_sys,
    input wire logic        reset,
    input wire logic        xtal_in,
    input wire logic        xtal_out,
    input wire logic        chain_sys_clock_in,
    input wire logic        rx_port_mode_sel,
    input wire logic        tx_port_mode_sel,
    input wire logic        bit_clock_out,
    input wire logic        chain_sys_clock_out,
    input wire logic        led_red,
    input wire logic        led_green,
    input wire logic        led_blue,
    input wire logic [1:0]  reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [15:0] reg_rdata
);
    timeunit 1ns;
    timeprecision 1ps;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    // ============================================================
    // Helper state
    logic [1:0] up_reg;
    logic [1:0] ctrl_reg;
    logic [8:0] off_reg;
    wire        live = (up_reg == 2'h3);

    // Past values are trusted only a few edges after reset, since they still see reset-time levels.
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            up_reg <= 2'h0;
            ctrl_reg <= 2'h3;
            off_reg <= 9'h000;
        end else begin
            up_reg <= live ? up_reg : up_reg + 2'h1;
            ctrl_reg <= (reg_wr && reg_addr == 2'h2) ? reg_wdata[1:0] : ctrl_reg;
            off_reg <= ctrl_reg[0] ? 9'h000 : ((off_reg == 9'h190) ? off_reg : off_reg + 9'h001);
        end
    end

    // ============================================================
    // Sequences and assertions
    sequence s_rd(logic [1:0] a);
        reg_rd && reg_addr == a;
    endsequence
    sequence s_chain_rise;
        $rose(chain_sys_clock_in) ##0 (live && rx_port_mode_sel && tx_port_mode_sel);
    endsequence

    AST_XTAL_INVERT: assert property (live |-> xtal_out == !$past(xtal_in))
        else $error("oscillator output is not the inverse of its input");
    AST_UNMAPPED_READ: assert property (s_rd(2'h3) |=> reg_rdata == 16'h0000)
        else $error("unmapped read returned data");
    AST_LEVEL_NIBBLES: assert property (s_rd(2'h0) |=> reg_rdata[15:12] == 4'h0)
        else $error("level word has bits above three nibbles");
    AST_STRAP_STATUS: assert property (s_rd(2'h1) ##0 (live && $stable(rx_port_mode_sel)
        && $stable(tx_port_mode_sel)) |=> reg_rdata[1:0] == $past({tx_port_mode_sel, rx_port_mode_sel}))
        else $error("status straps differ from the strap pins");
    AST_CTRL_READBACK: assert property (s_rd(2'h2) |=> reg_rdata[1:0] == $past(ctrl_reg))
        else $error("control readback differs from last write");
    AST_CODED_TX_NO_CLOCKS: assert property (!$past(tx_port_mode_sel, 2) && !$past(tx_port_mode_sel)
        && !tx_port_mode_sel |-> !bit_clock_out && !chain_sys_clock_out)
        else $error("clock outputs driven in coded output mode");
    AST_CHAIN_CLOCK_PASSED: assert property (s_chain_rise |-> ##[1:4] chain_sys_clock_out)
        else $error("system clock not passed downstream");
    AST_LEDS_DARK: assert property (off_reg == 9'h190 |-> !(led_red || led_green || led_blue))
        else $error("LED lit while outputs are disabled");
endmodule

bind crp_top crp_top_checker u_checker (
    .clk_sys(clk_sys), .reset(reset), .xtal_in(xtal_in), .xtal_out(xtal_out),
    .chain_sys_clock_in(chain_sys_clock_in), .rx_port_mode_sel(rx_port_mode_sel),
    .tx_port_mode_sel(tx_port_mode_sel), .bit_clock_out(bit_clock_out),
    .chain_sys_clock_out(chain_sys_clock_out), .led_red(led_red), .led_green(led_green),
    .led_blue(led_blue), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata)
);

// ===== tb/crp_upstream_model.sv
// ============================================================
// Upstream chain party sending clock-latched or line-coded frames.
module crp_upstream_model (
    input wire logic clk_sys,
    output logic     serial_in,
    output logic     bit_clock_in,
    output logic     chain_sys_clock_in
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [2:0] div_reg = 3'h0;

    // Idle levels; the bit clock rests high so the first bit starts on a fall.
    initial begin
        serial_in = 1'b0;
        bit_clock_in = 1'b1;
        chain_sys_clock_in = 1'b0;
    end

    // The upstream system clock runs free with an eight-cycle period.
    always @(posedge clk_sys) begin
        div_reg <= div_reg + 3'h1;
        chain_sys_clock_in <= div_reg[2];
    end

    // Each bit lasts two system periods; the last clock period is run out in full.
    task automatic send_latched(input logic [55:0] f, input int n);
        for (int i = n - 1; i >= 0; i--) begin
            serial_in <= f[i];
            bit_clock_in <= 1'b0;
            repeat (8) @(posedge clk_sys);
            bit_clock_in <= 1'b1;
            repeat (8) @(posedge clk_sys);
        end
        serial_in <= ~f[0];
    endtask

    // Half a bit is 32 oscillator periods of four cycles; the bit clock is left alone.
    task automatic send_coded(input logic [55:0] f, input int n);
        serial_in <= 1'b0;
        repeat (256) @(posedge clk_sys);
        for (int i = n - 1; i >= 0; i--) begin
            serial_in <= f[i];
            repeat (128) @(posedge clk_sys);
            serial_in <= ~f[i];
            repeat (128) @(posedge clk_sys);
        end
        serial_in <= 1'b0;
    endtask
endmodule

// ===== tb/test_cascade_rgb_pixel_link_pwm.sv
// ============================================================
// Compare macro
`define CHK(nm, e, g) \
    begin \
        tests_run++; \
        if ((g) !== (e)) begin \
            n_mismatch++; \
            $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); \
        end \
    end

module test_cascade_rgb_pixel_link_pwm;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [55:0] FRAME_A = {16'h0000, 12'hF60, 12'h5A3, 16'hC3A5};
    localparam logic [43:0] FWD_A   = {16'h0000, 12'h5A3, 16'hC3A5};
    localparam logic [55:0] FRAME_B = {16'h0000, 12'h3C9, 12'h7E1, 16'h5A5A};

    logic        clk_sys = 1'b0;
    logic        reset = 1'b1;
    logic        xtal_in = 1'b0;
    logic [1:0]  osc_reg = 2'h0;
    logic        rx_port_mode_sel = 1'b1;
    logic        tx_port_mode_sel = 1'b1;
    logic [1:0]  reg_addr = 2'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    wire logic   serial_in, bit_clock_in, chain_sys_clock_in, xtal_out;
    wire logic   serial_out, bit_clock_out, chain_sys_clock_out;
    wire logic   led_red, led_green, led_blue;
    wire logic [15:0] reg_rdata;
    int          n_mismatch = 0;
    int          tests_run = 0;
    int          fwd_n;
    int          edges_n;
    logic [43:0] fwd_reg;
    logic        bco_q;
    logic        so_q;

    // Clock and a four-cycle oscillator, so coded timing and PWM counts are exact.
    initial forever #2.5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        osc_reg <= osc_reg + 2'h1;
        xtal_in <= osc_reg[1];
    end

    crp_upstream_model up (.clk_sys(clk_sys), .serial_in(serial_in), .bit_clock_in(bit_clock_in),
        .chain_sys_clock_in(chain_sys_clock_in));

    crp_top dut (.clk_sys(clk_sys), .reset(reset), .xtal_in(xtal_in), .xtal_out(xtal_out),
        .serial_in(serial_in), .bit_clock_in(bit_clock_in), .chain_sys_clock_in(chain_sys_clock_in),
        .rx_port_mode_sel(rx_port_mode_sel), .tx_port_mode_sel(tx_port_mode_sel),
        .serial_out(serial_out), .bit_clock_out(bit_clock_out), .chain_sys_clock_out(chain_sys_clock_out),
        .led_red(led_red), .led_green(led_green), .led_blue(led_blue), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

    // Downstream watcher: bits taken on the outgoing bit clock, and line edges counted.
    always @(posedge clk_sys) begin
        bco_q <= bit_clock_out;
        so_q <= serial_out;
        if (reset) begin
            fwd_n <= 0;
            edges_n <= 0;
        end else begin
            if (bit_clock_out && !bco_q) fwd_reg <= {fwd_reg[42:0], serial_out};
            if (bit_clock_out && !bco_q) fwd_n <= fwd_n + 1;
            if (serial_out !== so_q) edges_n <= edges_n + 1;
        end
    end

    // ============================================================
    // Shared tasks
    task automatic do_reset();
        reset <= 1'b1;
        repeat (20) @(posedge clk_sys);
        reset <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic reg_write(input logic [1:0] a, input logic [15:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe, so they are taken mid-cycle.
    task automatic reg_check(input logic [1:0] a, input logic [15:0] e, input logic [15:0] m, input string nm);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        @(negedge clk_sys);
        `CHK(nm, e, reg_rdata & m)
        @(posedge clk_sys);
    endtask

    task automatic count_leds(input int cyc, output int r, output int g, output int b);
        r = 0;
        g = 0;
        b = 0;
        repeat (cyc) begin
            @(posedge clk_sys);
            r += (led_red === 1'b1);
            g += (led_green === 1'b1);
            b += (led_blue === 1'b1);
        end
    endtask

    task automatic finish_test();
        $display("comparisons %0d, mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // ============================================================
    // Scenarios
    task automatic test_regs();
        reg_check(2'h0, 16'h0000, 16'hFFFF, "levels at reset");
        reg_check(2'h2, 16'h0003, 16'h0003, "control at reset");
        reg_write(2'h0, 16'h0FFF);
        reg_check(2'h0, 16'h0000, 16'hFFFF, "levels after write");
        reg_check(2'h3, 16'h0000, 16'hFFFF, "unmapped read");
        reg_write(2'h2, 16'h0000);
        reg_check(2'h2, 16'h0000, 16'h0003, "control cleared");
        reg_write(2'h2, 16'h0003);
        for (int m = 0; m < 4; m++) begin
            {tx_port_mode_sel, rx_port_mode_sel} <= m[1:0];
            repeat (4) @(posedge clk_sys);
            reg_check(2'h1, {14'h0000, m[1:0]}, 16'h0003, "status straps");
        end
    endtask

    task automatic test_latched();
        int r;
        int g;
        int b;
        up.send_latched(FRAME_A, 56);
        repeat (800) @(posedge clk_sys);
        reg_check(2'h0, 16'h0F60, 16'hFFFF, "latched own pixel");
        `CHK("forwarded bit count", 44, fwd_n)
        `CHK("forwarded bits", FWD_A, fwd_reg)
        count_leds(128, r, g, b);
        `CHK("red slots", 128, r)
        `CHK("green slots", 48, g)
        `CHK("blue slots", 0, b)
        reg_write(2'h2, 16'h0002);
        repeat (450) @(posedge clk_sys);
        count_leds(128, r, g, b);
        `CHK("disabled slots", 0, r + g + b)
        reg_write(2'h2, 16'h0003);
    endtask

    // Coded in and coded out: one PWM period is 16 ticks of 32 oscillator periods.
    task automatic test_coded();
        int r;
        int g;
        int b;
        rx_port_mode_sel <= 1'b0;
        tx_port_mode_sel <= 1'b0;
        do_reset();
        up.send_coded(FRAME_B, 56);
        repeat (1500) @(posedge clk_sys);
        reg_check(2'h0, 16'h03C9, 16'hFFFF, "coded own pixel");
        count_leds(2048, r, g, b);
        `CHK("coded red slots", 384, r)
        `CHK("coded green slots", 1536, g)
        `CHK("coded blue slots", 1152, b)
        `CHK("coded output edges", 1'b1, edges_n >= 44)
    endtask

    // Watchdog: the whole run needs about 21000 cycles.
    initial begin
        repeat (60000) @(posedge clk_sys);
        n_mismatch++;
        $display("watchdog expired");
        finish_test();
    end

    initial begin
        do_reset();
        test_regs();
        test_latched();
        test_coded();
        finish_test();
    end
endmodule
